// ---- design/npb_page_ctrl.sv ----
// Page-buffer and page-programming controller for flash and EEPROM
// Behaviour
// - Flash buffer loads one 16-bit word per load; clear before loading.
// - Unloaded flash buffer words hold FFFF and are programmed as such.
// - Flash buffer clears on reset and after page write, erase-write, signature, lock.
// - EEPROM buffer loads one byte per load; clear before loading.
// - Loaded EEPROM bytes are tagged; erase and write touch only tagged bytes.
// - EEPROM buffer and tags clear on reset, page write, erase-write, lock, fuse.
// - EEPROM updates single bytes or pages; flash only whole pages from buffer.
// - Software and external programmer use the same controller identically.
// - Buffer may be filled before split, before atomic, or between erase and write.
// - Flash write forces brown-out detector on; brown-out reset aborts at once.
// - Application-section programming lets CPU run from the boot section.
// - Boot-section programming halts CPU for the whole operation.
// - Signature row programming halts CPU like the boot section.
// - CPU access to application section during flash or signature programming stalls until done.
// - Boot code may write all flash, signature row, EEPROM, tighten locks.
// - Application code may only read flash and rows, and write EEPROM.
// - While busy, busy flag is set and new command and data writes ignored.
// - While programming, buffer loads and clears are rejected.
module npb_page_ctrl
    import npb_pkg::*;
#(
    parameter int FLASH_WORDS = FLASH_WORDS_DEF,
    parameter int EE_BYTES    = EE_BYTES_DEF,
    parameter int OP_CYCLES   = OP_CYCLES_DEF,
    parameter int FW          = $clog2(FLASH_WORDS),
    parameter int EW          = $clog2(EE_BYTES)
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // Brown-out
    input  wire logic                    brownoutReset,
    output logic                         brownoutForceOn,
    // Flash buffer port, shared by CPU and external programmer
    input  wire logic                    flashLoad,
    input  wire logic [FW-1:0]           flashLoadIdx,
    input  wire logic [FLASH_WORD_W-1:0] flashLoadData,
    input  wire logic                    flashClear,
    // EEPROM buffer port
    input  wire logic                    eeLoad,
    input  wire logic [EW-1:0]           eeLoadIdx,
    input  wire logic [EE_BYTE_W-1:0]    eeLoadData,
    input  wire logic                    eeClear,
    // Operation request
    input  wire logic                    reqValid,
    input  wire npb_req_s                req,
    output logic                         reqRejected,
    // Status and CPU control
    output logic                         busy,
    output logic                         cpuHalt,
    input  wire logic                    cpuAppAccess,
    output logic                         cpuStall,
    // Array side
    output logic                         arrValid,
    output logic                         arrFlash,
    output logic                         arrErase,
    output logic                         arrWrite,
    output logic [15:0]                  arrPage,
    output logic [FW-1:0]                arrIdx,
    output logic [FLASH_WORD_W-1:0]      arrData
);
    localparam int CW = $clog2(OP_CYCLES + 1);

    npb_state_e              state_reg;
    npb_req_s                op_reg;
    logic [FW:0]             idx_reg;
    logic [CW-1:0]           wait_reg;
    logic                    idxPhase_reg;
    logic                    done;
    logic                    accept;
    logic                    allowed;
    logic                    isFlashOp;
    logic                    isEeOp;
    logic                    flashBufClear;
    logic                    eeBufClear;
    logic [FLASH_WORD_W-1:0] flashRd;
    logic [EE_BYTE_W-1:0]    eeRd;
    logic                    eeTag;
    logic [FW-1:0]           lastIdx;

    // Privilege check; identical for either requesting party
    always_comb begin
        unique case (req.cmd)
            NPB_CMD_EE_ERASE, NPB_CMD_EE_WRITE, NPB_CMD_EE_EW: allowed = 1'b1;
            NPB_CMD_NONE: allowed = 1'b0;
            default: allowed = req.fromBoot;
        endcase
    end

    assign accept = reqValid && (state_reg == NPB_ST_IDLE) && allowed;
    assign reqRejected = reqValid && !accept;

    assign isFlashOp = op_reg.cmd inside {NPB_CMD_FLASH_ERASE, NPB_CMD_FLASH_WRITE, NPB_CMD_FLASH_EW,
                                          NPB_CMD_SIG_ERASE, NPB_CMD_SIG_WRITE};
    assign isEeOp = op_reg.cmd inside {NPB_CMD_EE_ERASE, NPB_CMD_EE_WRITE, NPB_CMD_EE_EW};
    assign lastIdx = isFlashOp ? FW'(FLASH_WORDS - 1) : FW'(EE_BYTES - 1);

    always_ff @(posedge core_clk) begin
        if (rst || brownoutReset) begin
            state_reg <= NPB_ST_IDLE;
            op_reg    <= '0;
        end else if (accept) begin
            state_reg <= NPB_ST_BUSY;
            op_reg    <= req;
        end else if (done) begin
            state_reg <= NPB_ST_IDLE;
        end
    end

    // Walk every buffer location once; a fixed hold per location models array time
    always_ff @(posedge core_clk) begin
        if (rst || brownoutReset || accept) begin
            idx_reg      <= '0;
            wait_reg     <= '0;
            idxPhase_reg <= 1'b0;
        end else if (state_reg == NPB_ST_BUSY) begin
            idxPhase_reg <= 1'b1;
            if (idxPhase_reg && wait_reg == CW'(OP_CYCLES - 1)) begin
                wait_reg     <= '0;
                idx_reg      <= idx_reg + 1'b1;
                idxPhase_reg <= 1'b0;
            end else if (idxPhase_reg) begin
                wait_reg <= wait_reg + 1'b1;
            end
        end
    end

    // Lock and fuse writes have no page to walk
    assign done = (state_reg == NPB_ST_BUSY) &&
                  ((op_reg.cmd inside {NPB_CMD_LOCK_WRITE, NPB_CMD_FUSE_WRITE}) ||
                   (idxPhase_reg && wait_reg == CW'(OP_CYCLES - 1) && idx_reg[FW-1:0] == lastIdx));

    // Buffer data is registered one cycle after idx, so the array strobe waits a phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            arrValid <= 1'b0;
            arrFlash <= 1'b0;
            arrErase <= 1'b0;
            arrWrite <= 1'b0;
            arrPage  <= '0;
            arrIdx   <= '0;
            arrData  <= '0;
        end else begin
            arrValid <= 1'b0;
            if (state_reg == NPB_ST_BUSY && idxPhase_reg && wait_reg == '0 && !brownoutReset) begin
                arrFlash <= isFlashOp;
                arrErase <= op_reg.cmd inside {NPB_CMD_FLASH_ERASE, NPB_CMD_FLASH_EW, NPB_CMD_SIG_ERASE,
                                               NPB_CMD_EE_ERASE, NPB_CMD_EE_EW};
                arrWrite <= op_reg.cmd inside {NPB_CMD_FLASH_WRITE, NPB_CMD_FLASH_EW, NPB_CMD_SIG_WRITE,
                                               NPB_CMD_EE_WRITE, NPB_CMD_EE_EW};
                arrPage  <= op_reg.page;
                arrIdx   <= idx_reg[FW-1:0];
                arrValid <= isFlashOp || (isEeOp && eeTag);
                arrData  <= isFlashOp ? flashRd : {{(FLASH_WORD_W - EE_BYTE_W){1'b0}}, eeRd};
            end
        end
    end

    assign busy = (state_reg == NPB_ST_BUSY);

    // Automatic clears follow successful completion only
    assign flashBufClear = (flashClear && !busy) ||
        (done && (op_reg.cmd inside {NPB_CMD_FLASH_WRITE, NPB_CMD_FLASH_EW,
                                     NPB_CMD_SIG_WRITE, NPB_CMD_LOCK_WRITE}));
    assign eeBufClear = (eeClear && !busy) ||
        (done && (op_reg.cmd inside {NPB_CMD_EE_WRITE, NPB_CMD_EE_EW,
                                     NPB_CMD_LOCK_WRITE, NPB_CMD_FUSE_WRITE}));

    // Brown-out detector held on through any flash programming
    always_ff @(posedge core_clk) begin
        if (rst || brownoutReset) begin
            brownoutForceOn <= 1'b0;
        end else begin
            brownoutForceOn <= (accept && req.cmd inside {NPB_CMD_FLASH_ERASE, NPB_CMD_FLASH_WRITE,
                                    NPB_CMD_FLASH_EW, NPB_CMD_SIG_ERASE, NPB_CMD_SIG_WRITE}) ||
                               (brownoutForceOn && !done);
        end
    end

    // Halt on boot or signature section work; app-section work only stalls on access
    assign cpuHalt  = busy && isFlashOp && (op_reg.section != NPB_SEC_APP);
    assign cpuStall = busy && isFlashOp && cpuAppAccess;

    npb_flash_buf #(
        .DEPTH (FLASH_WORDS)
    ) u_flash_buf (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (flashBufClear),
        .load     (flashLoad && !busy),
        .loadIdx  (flashLoadIdx),
        .loadData (flashLoadData),
        .rdIdx    (idx_reg[FW-1:0]),
        .rdData   (flashRd)
    );

    npb_ee_buf #(
        .DEPTH (EE_BYTES)
    ) u_ee_buf (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (eeBufClear),
        .load     (eeLoad && !busy),
        .loadIdx  (eeLoadIdx),
        .loadData (eeLoadData),
        .rdIdx    (idx_reg[EW-1:0]),
        .rdData   (eeRd),
        .rdTag    (eeTag)
    );
endmodule : npb_page_ctrl

// ---- shared/npb_pkg.sv ----
// Package for the non-volatile memory page-buffer controller
package npb_pkg;

    localparam int FLASH_WORDS_DEF = 64;
    localparam int EE_BYTES_DEF    = 32;
    localparam int FLASH_WORD_W    = 16;
    localparam int EE_BYTE_W       = 8;
    localparam logic [15:0] FLASH_ERASED = 16'hFFFF;
    localparam logic [7:0]  EE_ERASED    = 8'hFF;
    localparam int OP_CYCLES_DEF   = 16;

    typedef enum logic [3:0] {
        NPB_CMD_NONE        = 4'b0000,
        NPB_CMD_FLASH_ERASE = 4'b0001,
        NPB_CMD_FLASH_WRITE = 4'b0010,
        NPB_CMD_FLASH_EW    = 4'b0011,
        NPB_CMD_SIG_ERASE   = 4'b0100,
        NPB_CMD_SIG_WRITE   = 4'b0101,
        NPB_CMD_LOCK_WRITE  = 4'b0110,
        NPB_CMD_FUSE_WRITE  = 4'b0111,
        NPB_CMD_EE_ERASE    = 4'b1000,
        NPB_CMD_EE_WRITE    = 4'b1001,
        NPB_CMD_EE_EW       = 4'b1010
    } npb_cmd_e;

    typedef enum logic [1:0] {
        NPB_SEC_APP  = 2'b00,
        NPB_SEC_BOOT = 2'b01,
        NPB_SEC_SIG  = 2'b10
    } npb_sec_e;

    typedef enum logic [0:0] {
        NPB_ST_IDLE = 1'b0,
        NPB_ST_BUSY = 1'b1
    } npb_state_e;

    // One operation request to the controller
    typedef struct packed {
        npb_cmd_e    cmd;
        npb_sec_e    section;
        logic [15:0] page;
        logic        fromBoot;
    } npb_req_s;

endpackage : npb_pkg

// ---- design/npb_flash_buf.sv ----
// Word-wide flash page buffer; unloaded words read as erased
module npb_flash_buf
    import npb_pkg::*;
#(
    parameter int DEPTH = FLASH_WORDS_DEF,
    parameter int IW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // Load and clear
    input  wire logic                    clear,
    input  wire logic                    load,
    input  wire logic [IW-1:0]           loadIdx,
    input  wire logic [FLASH_WORD_W-1:0] loadData,
    // Drain to array
    input  wire logic [IW-1:0]           rdIdx,
    output logic      [FLASH_WORD_W-1:0] rdData
);
    logic [FLASH_WORD_W-1:0] mem_reg [DEPTH];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_word
            always_ff @(posedge core_clk) begin
                if (rst || clear) begin
                    mem_reg[i] <= FLASH_ERASED;
                end else if (load && loadIdx == IW'(i)) begin
                    mem_reg[i] <= loadData;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData <= FLASH_ERASED;
        end else begin
            rdData <= mem_reg[rdIdx];
        end
    end
endmodule : npb_flash_buf

// ---- design/npb_ee_buf.sv ----
// Byte-wide EEPROM page buffer with per-byte load tags
module npb_ee_buf
    import npb_pkg::*;
#(
    parameter int DEPTH = EE_BYTES_DEF,
    parameter int IW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // Load and clear
    input  wire logic                 clear,
    input  wire logic                 load,
    input  wire logic [IW-1:0]        loadIdx,
    input  wire logic [EE_BYTE_W-1:0] loadData,
    // Drain to array
    input  wire logic [IW-1:0]        rdIdx,
    output logic      [EE_BYTE_W-1:0] rdData,
    output logic                      rdTag
);
    logic [EE_BYTE_W-1:0] mem_reg [DEPTH];
    logic [DEPTH-1:0]     tag_reg;

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_byte
            always_ff @(posedge core_clk) begin
                if (rst || clear) begin
                    mem_reg[i] <= EE_ERASED;
                    tag_reg[i] <= 1'b0;
                end else if (load && loadIdx == IW'(i)) begin
                    mem_reg[i] <= loadData;
                    tag_reg[i] <= 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData <= EE_ERASED;
            rdTag  <= 1'b0;
        end else begin
            rdData <= mem_reg[rdIdx];
            rdTag  <= tag_reg[rdIdx];
        end
    end
endmodule : npb_ee_buf

// ---- verif/npb_page_ctrl_monitor.sv ----
// Port checker for the page-buffer controller
module npb_page_ctrl_monitor
    import npb_pkg::*;
#(
    parameter int FLASH_WORDS = FLASH_WORDS_DEF,
    parameter int FW          = $clog2(FLASH_WORDS)
) (
    input wire logic          core_clk,
    input wire logic          rst,
    input wire logic          brownoutReset,
    input wire logic          brownoutForceOn,
    input wire logic          reqValid,
    input wire npb_req_s      req,
    input wire logic          reqRejected,
    input wire logic          busy,
    input wire logic          cpuHalt,
    input wire logic          cpuAppAccess,
    input wire logic          cpuStall,
    input wire logic          arrValid,
    input wire logic          arrFlash,
    input wire logic [FW-1:0] arrIdx
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire take = reqValid && !busy && !reqRejected && !brownoutReset;
    wire isEe = req.cmd inside {NPB_CMD_EE_ERASE, NPB_CMD_EE_WRITE, NPB_CMD_EE_EW};
    sequence s_take_prog;
        take && req.cmd inside {NPB_CMD_FLASH_ERASE, NPB_CMD_FLASH_WRITE, NPB_CMD_FLASH_EW,
                                NPB_CMD_SIG_ERASE, NPB_CMD_SIG_WRITE};
    endsequence
    sequence s_take_fwr;
        take && req.cmd inside {NPB_CMD_FLASH_WRITE, NPB_CMD_FLASH_EW};
    endsequence
    a_take_sets_busy: assert property (take |=> busy)
        else $error("busy not raised after accepted request");
    a_busy_rejects: assert property (reqValid && busy |-> reqRejected)
        else $error("request accepted while busy");
    a_app_refused: assert property (reqValid && !req.fromBoot && !isEe |-> reqRejected)
        else $error("application code allowed a non-eeprom command");
    a_force_bod: assert property (s_take_prog |=> brownoutForceOn)
        else $error("brown-out detector not forced on");
    a_bod_abort: assert property (busy && brownoutReset |=> !busy && !brownoutForceOn)
        else $error("brown-out did not abort the operation");
    a_boot_halts: assert property (s_take_prog ##0 req.section != NPB_SEC_APP |=> cpuHalt [*2])
        else $error("cpu not halted for boot or signature programming");
    a_app_runs: assert property (s_take_prog ##0 req.section == NPB_SEC_APP |=> !cpuHalt)
        else $error("cpu halted for application programming");
    a_halt_busy: assert property (cpuHalt |-> busy)
        else $error("cpu halted while idle");
    a_stall_cause: assert property (cpuStall |-> busy && cpuAppAccess)
        else $error("stall without access during programming");
    a_first_word: assert property (s_take_fwr |-> ##3 arrValid && arrFlash && arrIdx == '0)
        else $error("page write did not start at word zero");
endmodule : npb_page_ctrl_monitor

bind npb_page_ctrl npb_page_ctrl_monitor #(.FLASH_WORDS(FLASH_WORDS), .FW(FW)) i_mon (
    .core_clk(core_clk), .rst(rst), .brownoutReset(brownoutReset), .brownoutForceOn(brownoutForceOn),
    .reqValid(reqValid), .req(req), .reqRejected(reqRejected), .busy(busy), .cpuHalt(cpuHalt),
    .cpuAppAccess(cpuAppAccess), .cpuStall(cpuStall), .arrValid(arrValid), .arrFlash(arrFlash),
    .arrIdx(arrIdx));

// ---- verif/npb_host_model.sv ----
// Behavioural loader standing for boot code or an external programmer
module npb_host
    import npb_pkg::*;
#(
    parameter int FW = 2,
    parameter int EW = 2
) (
    // Clock and status
    input  wire logic     core_clk,
    input  wire logic     busy,
    // Buffer strobes
    output logic          flashLoad,
    output logic [FW-1:0] flashLoadIdx,
    output logic [15:0]   flashLoadData,
    output logic          flashClear,
    output logic          eeLoad,
    output logic [EW-1:0] eeLoadIdx,
    output logic [7:0]    eeLoadData,
    output logic          eeClear,
    // Requests
    output logic          reqValid,
    output npb_req_s      req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {flashLoad, flashClear, eeLoad, eeClear, reqValid} = '0;
        {flashLoadIdx, flashLoadData, eeLoadIdx, eeLoadData, req} = '0;
    end
    // Each place is loaded once per clear; a reload would overwrite it with the new data
    task automatic loadFlash(input logic [FW-1:0] idx, input logic [15:0] data);
        @(negedge core_clk);
        flashLoad = 1'h1;
        flashLoadIdx = idx;
        flashLoadData = data;
        @(negedge core_clk);
        flashLoad = 1'h0;
        flashLoadData = ~flashLoadData;
    endtask : loadFlash
    task automatic loadEe(input logic [EW-1:0] idx, input logic [7:0] data);
        @(negedge core_clk);
        eeLoad = 1'h1;
        eeLoadIdx = idx;
        eeLoadData = data;
        @(negedge core_clk);
        eeLoad = 1'h0;
        eeLoadData = ~eeLoadData;
    endtask : loadEe
    task automatic clearBufs();
        @(negedge core_clk);
        {flashClear, eeClear} = 2'h3;
        @(negedge core_clk);
        {flashClear, eeClear} = 2'h0;
    endtask : clearBufs
    // Same strobes whichever party is programming
    task automatic issue(input npb_cmd_e cmd, input npb_sec_e sec, input logic [15:0] page,
                         input logic boot);
        @(negedge core_clk);
        reqValid = 1'h1;
        req = '{cmd, sec, page, boot};
        @(negedge core_clk);
        reqValid = 1'h0;
        req.page = ~req.page;
    endtask : issue
    task automatic waitDone();
        for (int n = 0; n < 200 && busy; n++) @(negedge core_clk);
    endtask : waitDone
endmodule : npb_host

// ---- verif/tb_npb_page_ctrl.sv ----
// Self-checking bench for the page-buffer controller
module tb_npb_page_ctrl
    import npb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, brownoutReset, cpuAppAccess, flashLoad, flashClear, eeLoad, eeClear, reqValid;
    logic brownoutForceOn, reqRejected, busy, cpuHalt, cpuStall, arrValid, arrFlash, arrErase, arrWrite;
    logic [1:0] flashLoadIdx, eeLoadIdx, arrIdx;
    logic [15:0] flashLoadData, arrPage, arrData, flashImg [4];
    logic [7:0] eeLoadData, eeLast;
    logic haltAny, stallAny, rejAny;
    npb_req_s req;
    int eeHits, ersHits, mismatches, comparisons;
    npb_host #(.FW(2), .EW(2)) i_host (.core_clk, .busy, .flashLoad, .flashLoadIdx, .flashLoadData,
        .flashClear, .eeLoad, .eeLoadIdx, .eeLoadData, .eeClear, .reqValid, .req);
    npb_page_ctrl #(.FLASH_WORDS(4), .EE_BYTES(4), .OP_CYCLES(2)) i_dut (.core_clk, .rst, .brownoutReset,
        .brownoutForceOn, .flashLoad, .flashLoadIdx, .flashLoadData, .flashClear, .eeLoad, .eeLoadIdx,
        .eeLoadData, .eeClear, .reqValid, .req, .reqRejected, .busy, .cpuHalt, .cpuAppAccess, .cpuStall,
        .arrValid, .arrFlash, .arrErase, .arrWrite, .arrPage, .arrIdx, .arrData);
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    // Array stand-in: records what reaches each page location
    always @(posedge core_clk) begin
        if (arrValid && arrFlash && arrWrite) flashImg[arrIdx] = arrData;
        if (arrValid && !arrFlash) eeHits++;
        if (arrValid && !arrFlash) eeLast = arrData[7:0];
        if (arrValid && arrErase) ersHits++;
        haltAny |= busy && cpuHalt;
        stallAny |= cpuStall;
        rejAny |= reqValid && reqRejected;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic clr();
        flashImg = '{default: 16'h0000};
        {eeHits, ersHits, haltAny, stallAny, rejAny} = '0;
    endtask : clr
    task automatic run(input npb_cmd_e cmd, input npb_sec_e sec, input logic boot);
        clr();
        i_host.issue(cmd, sec, 16'h0005, boot);
        i_host.waitDone();
        check(busy, 1'h0);
    endtask : run
    task automatic t_fill_first();
        i_host.clearBufs();
        i_host.loadFlash(2'h1, 16'h1234);
        i_host.loadFlash(2'h3, 16'hA5A5);
        run(NPB_CMD_FLASH_ERASE, NPB_SEC_BOOT, 1'h1);
        check(ersHits, 16'h0004);
        run(NPB_CMD_FLASH_WRITE, NPB_SEC_BOOT, 1'h1);
        check(ersHits, 16'h0000);
        check(flashImg[0], 16'hFFFF);
        check(flashImg[1], 16'h1234);
        check(flashImg[3], 16'hA5A5);
        check(haltAny, 1'h1);
        check(arrPage, 16'h0005);
    endtask : t_fill_first
    task automatic t_fill_between();
        i_host.clearBufs();
        clr();
        i_host.issue(NPB_CMD_FLASH_ERASE, NPB_SEC_APP, 16'h0005, 1'h1);
        cpuAppAccess = 1'h1;
        i_host.loadFlash(2'h0, 16'hDEAD);
        i_host.issue(NPB_CMD_FLASH_WRITE, NPB_SEC_APP, 16'h0005, 1'h1);
        i_host.waitDone();
        check(busy, 1'h0);
        cpuAppAccess = 1'h0;
        check({haltAny, stallAny, rejAny}, 3'h3);
        i_host.loadFlash(2'h2, 16'h0F0F);
        run(NPB_CMD_FLASH_WRITE, NPB_SEC_APP, 1'h1);
        check(flashImg[0], 16'hFFFF);
        check(flashImg[2], 16'h0F0F);
    endtask : t_fill_between
    task automatic t_ee_tags();
        i_host.clearBufs();
        i_host.loadEe(2'h2, 8'h3C);
        run(NPB_CMD_EE_ERASE, NPB_SEC_APP, 1'h0);
        check(eeHits, 1);
        check(ersHits, 16'h0001);
        run(NPB_CMD_EE_WRITE, NPB_SEC_APP, 1'h0);
        check({eeHits[7:0], eeLast}, 16'h013C);
        run(NPB_CMD_EE_WRITE, NPB_SEC_APP, 1'h0);
        check(eeHits, 0);
    endtask : t_ee_tags
    task automatic t_auto_clear();
        npb_cmd_e fc [4] = '{NPB_CMD_FLASH_WRITE, NPB_CMD_FLASH_EW, NPB_CMD_SIG_WRITE, NPB_CMD_LOCK_WRITE};
        npb_cmd_e ec [4] = '{NPB_CMD_EE_WRITE, NPB_CMD_EE_EW, NPB_CMD_LOCK_WRITE, NPB_CMD_FUSE_WRITE};
        for (int k = 0; k < 4; k++) begin
            i_host.clearBufs();
            i_host.loadFlash(2'h0, 16'h7777);
            run(fc[k], (fc[k] == NPB_CMD_SIG_WRITE) ? NPB_SEC_SIG : NPB_SEC_BOOT, 1'h1);
            check(haltAny, fc[k] != NPB_CMD_LOCK_WRITE);
            run(NPB_CMD_FLASH_WRITE, NPB_SEC_BOOT, 1'h1);
            check(flashImg[0], 16'hFFFF);
            i_host.clearBufs();
            i_host.loadEe(2'h1, 8'h11);
            run(ec[k], NPB_SEC_APP, 1'h1);
            run(NPB_CMD_EE_WRITE, NPB_SEC_APP, 1'h1);
            check(eeHits, 0);
        end
    endtask : t_auto_clear
    // A mid-run system reset must drop loaded words and tags
    task automatic t_reset_clear();
        i_host.clearBufs();
        i_host.loadFlash(2'h1, 16'h4321);
        i_host.loadEe(2'h0, 8'h22);
        @(negedge core_clk);
        rst = 1'h1;
        @(negedge core_clk);
        rst = 1'h0;
        run(NPB_CMD_FLASH_WRITE, NPB_SEC_BOOT, 1'h1);
        check(flashImg[1], 16'hFFFF);
        run(NPB_CMD_EE_WRITE, NPB_SEC_APP, 1'h0);
        check(eeHits, 0);
    endtask : t_reset_clear
    task automatic t_refuse_and_abort();
        run(NPB_CMD_SIG_ERASE, NPB_SEC_SIG, 1'h1);
        check({haltAny, brownoutForceOn}, 2'h2);
        run(NPB_CMD_FLASH_WRITE, NPB_SEC_APP, 1'h0);
        check({rejAny, busy}, 2'h2);
        i_host.issue(NPB_CMD_FLASH_WRITE, NPB_SEC_APP, 16'h0005, 1'h1);
        repeat (3) @(negedge core_clk);
        check(brownoutForceOn, 1'h1);
        brownoutReset = 1'h1;
        @(negedge core_clk);
        brownoutReset = 1'h0;
        check({busy, brownoutForceOn}, 2'h0);
    endtask : t_refuse_and_abort
    initial begin
        {rst, brownoutReset, cpuAppAccess} = 3'h4;
        {mismatches, comparisons} = '0;
        clr();
        repeat (6) @(negedge core_clk);
        rst = 1'h0;
        t_fill_first();
        t_fill_between();
        t_ee_tags();
        t_auto_clear();
        t_reset_clear();
        t_refuse_and_abort();
        stop_test();
    end
    // Whole run needs a few hundred cycles; this limit only catches a hang
    initial begin
        #100us;
        mismatches++;
        stop_test();
    end
endmodule : tb_npb_page_ctrl
